// ===== hdl/apfcs_defines.vh
// register map, field positions, reset values and timing counts of the compare sequencer
`ifndef APFCS_DEFINES_VH
`define APFCS_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define APFCS_OFF_MODE0     8'h00
`define APFCS_OFF_MODE2     8'h04
`define APFCS_OFF_SEL       8'h08
`define APFCS_OFF_PFM       8'h0C
`define APFCS_OFF_PFT       8'h10
`define APFCS_OFF_STAT      8'h14
`define APFCS_OFF_RES_BASE  8'h40
`define APFCS_OFF_RES_LAST  8'h6C

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define APFCS_MODE0_CE      7
`define APFCS_MODE0_BUSY    6
`define APFCS_MODE0_MD_HI   5
`define APFCS_MODE0_MD_LO   4
`define APFCS_PFM_EN        7
`define APFCS_PFM_POL       6
`define APFCS_STAT_FLAG     0
`define APFCS_STAT_STALE    1

// ---------------------------------------------------------------
// operation mode codes and channel limits
// ---------------------------------------------------------------
`define APFCS_MD_CSEL       2'h0
`define APFCS_MD_CSCAN      2'h1
`define APFCS_MD_OSCAN      2'h2
`define APFCS_LAST_CH       4'hB
`define APFCS_NUM_CH        12
`define APFCS_RES_W         10

// ---------------------------------------------------------------
// reset values and bus answers
// ---------------------------------------------------------------
`define APFCS_RST_BYTE      8'h00
`define APFCS_RST_SEL       4'h0
`define APFCS_RESP_OKAY     2'h0
`define APFCS_RESP_SLVERR   2'h2

// ---------------------------------------------------------------
// timing: times in ns, counts derived at the 20 MHz clock
// ---------------------------------------------------------------
`define APFCS_CLK_MHZ       20
`define APFCS_STAB_NS       1000
`define APFCS_STAB_CYC      ((`APFCS_STAB_NS * `APFCS_CLK_MHZ + 999) / 1000)
`define APFCS_SAMP_NS       500
`define APFCS_SAMP_CYC      ((`APFCS_SAMP_NS * `APFCS_CLK_MHZ + 999) / 1000)
`define APFCS_SETTLE_CYC    3

`endif

// ===== hdl/apfcs_sync.v
// two-flop synchroniser bank for inputs from outside the clock domain
`timescale 1ns/100ps
`include "apfcs_defines.vh"

module apfcs_sync #(
	parameter W = 3
) (
	input  wire         sys_clk,
	input  wire         rst,
	input  wire         clk_en,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);

	// ---------------------------------------------------------------
	// per-bit stages; first flop feeds only the second
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
			reg meta_q;
			reg stab_q;
			always @(posedge sys_clk) begin
				if (rst) begin
					meta_q <= 1'b0;
					stab_q <= 1'b0;
				end else if (clk_en) begin
					meta_q <= async_in[gi];
					stab_q <= meta_q;
				end
			end
			assign sync_out[gi] = stab_q;
		end
	endgenerate

endmodule // apfcs_sync

// ===== hdl/apfcs_sar.v
// successive-approximation engine: drives the trial code, reads the comparator
`timescale 1ns/100ps
`include "apfcs_defines.vh"

module apfcs_sar (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        clk_en,
	input  wire        start,
	input  wire        kill,
	input  wire        comp_s,
	output reg  [9:0]  dac_q,
	output reg         done_q,
	output reg  [9:0]  res_q
);

	reg        run_q;
	reg [3:0]  bit_q;
	reg [1:0]  wait_q;

	localparam [1:0] SETTLE_LAST = `APFCS_SETTLE_CYC - 1;

	// ---------------------------------------------------------------
	// one bit per settle window; comparator high keeps the trial bit
	// ---------------------------------------------------------------
	// settle covers the two synchroniser flops plus the analog step
	always @(posedge sys_clk) begin
		if (rst) begin
			run_q  <= 1'b0;
			bit_q  <= 4'h0;
			wait_q <= 2'h0;
			dac_q  <= 10'h000;
			done_q <= 1'b0;
			res_q  <= 10'h000;
		end else if (clk_en) begin
			done_q <= 1'b0;
			if (kill) begin
				run_q <= 1'b0;
				dac_q <= 10'h000;
			end else if (start) begin
				run_q  <= 1'b1;
				bit_q  <= 4'h9;
				wait_q <= SETTLE_LAST;
				dac_q  <= 10'h200;
			end else if (run_q) begin
				if (wait_q != 2'h0) begin
					wait_q <= wait_q - 2'h1;
				end else begin
					if (!comp_s)
						dac_q[bit_q] <= 1'b0;
					if (bit_q == 4'h0) begin
						run_q  <= 1'b0;
						done_q <= 1'b1;
						res_q  <= comp_s ? dac_q : (dac_q & ~10'h001);
					end else begin
						dac_q[bit_q - 4'h1] <= 1'b1;
						bit_q  <= bit_q - 4'h1;
						wait_q <= SETTLE_LAST;
					end
				end
			end
		end
	end

endmodule // apfcs_sar

// ===== hdl/apfcs_top.v
// converter sequencer with power-fail compare and an AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "apfcs_defines.vh"

// Contract
// R1 - select mode: store every result, compare gates irq
// R2 - select mode restarts until enable cleared
// R3 - scan: only channel 0 high byte compared
// R4 - continuous scan 0..last, then restart
// R5 - one-shot scan 0..last, then halt
// R6 - enable clear keeps converter powered down
// R7 - select rewrite leaves irq flag untouched
// R8 - software clears flag before restarting
// R9 - config writes may spoil results
// R10 - trigger acknowledge may spoil results
// R11 - deepest standby stops converter, results invalid
// R12 - software toggles enable around standby
// R13 - idle and subclock keep converting
// R14 - results after idle release invalid
// R15 - no config writes during stabilisation
// R16 - convert twice, discard first
// R17 - compare off: irq every completion
// R18 - polarity 0 ge, polarity 1 lt
// R19 - stabilisation counter, parameter length
// R20 - compare uses threshold at store time
module apfcs_top #(
	parameter [15:0] STAB_CYCLES = `APFCS_STAB_CYC
) (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        clk_en,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        comp_in,
	input  wire        stop_mode,
	input  wire        idle_mode,
	output reg  [3:0]  chan_sel_q,
	output wire [9:0]  dac_code,
	output reg         sample_en_q,
	output reg         analog_pwr_en_q,
	output reg         conv_end_irq
);

	// ---------------------------------------------------------------
	// state codes
	// ---------------------------------------------------------------
	localparam [5:0] ST_OFF  = 6'h01;
	localparam [5:0] ST_STAB = 6'h02;
	localparam [5:0] ST_SAMP = 6'h04;
	localparam [5:0] ST_CONV = 6'h08;
	localparam [5:0] ST_HALT = 6'h10;
	localparam [5:0] ST_NEXT = 6'h20;

	localparam [15:0] SAMP_CYCLES = `APFCS_SAMP_CYC;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	reg  [5:0]  st_q;
	reg  [15:0] cnt_q;
	reg         ce_q;
	reg  [1:0]  md_q;
	reg  [7:0]  mode2_q;
	reg  [3:0]  sel_q;
	reg         pf_en_q;
	reg         pf_pol_q;
	reg  [7:0]  pft_q;
	reg         flag_q;
	reg         stale_q;
	reg         cmp0_q;
	reg         cfg_wr_q;
	reg         sar_go_q;
	reg         sar_kill_q;
	reg         stop_p_q;
	reg         idle_p_q;
	reg  [9:0]  res_q [0:`APFCS_NUM_CH-1];
	reg         aw_have_q;
	reg         w_have_q;
	reg  [7:0]  awaddr_q;
	reg  [7:0]  wbyte_q;
	reg         wlane0_q;
	wire [2:0]  sync_s;
	wire        comp_s;
	wire        stop_s;
	wire        idle_s;
	wire [9:0]  sar_res;
	wire        sar_done;
	wire [3:0]  last_ch;
	wire [3:0]  first_ch;
	wire        scan_md;
	wire        pf_hit;
	wire        wr_go;
	wire        wr_map;
	wire        wr_cfg;
	wire [3:0]  wr_idx;
	wire [3:0]  rd_idx;
	reg  [31:0] rd_data;
	reg         rd_ok;
	integer     ri;

	// ---------------------------------------------------------------
	// pin synchronisers and conversion engine
	// ---------------------------------------------------------------
	apfcs_sync #(
		.W        (3)
	) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.async_in ({idle_mode, stop_mode, comp_in}),
		.sync_out (sync_s)
	);

	assign comp_s = sync_s[0];
	assign stop_s = sync_s[1];
	assign idle_s = sync_s[2];

	apfcs_sar u_sar (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.start    (sar_go_q),
		.kill     (sar_kill_q),
		.comp_s   (comp_s),
		.dac_q    (dac_code),
		.done_q   (sar_done),
		.res_q    (sar_res)
	);

	// ---------------------------------------------------------------
	// channel range and threshold compare
	// ---------------------------------------------------------------
	// out-of-range select codes clamp to the top pin
	assign last_ch  = (sel_q > `APFCS_LAST_CH) ? `APFCS_LAST_CH : sel_q;
	assign scan_md  = (md_q == `APFCS_MD_CSCAN) || (md_q == `APFCS_MD_OSCAN);
	assign first_ch = scan_md ? 4'h0 : last_ch;
	// live threshold, sampled as the result is stored
	assign pf_hit   = !pf_en_q ? 1'b1 :                                      // R17
	                  (pf_pol_q ? (sar_res[9:2] < pft_q) : (sar_res[9:2] >= pft_q)); // R18 R20

	// ---------------------------------------------------------------
	// conversion sequencer
	// ---------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (rst) begin
			st_q            <= ST_OFF;
			cnt_q           <= 16'h0000;
			chan_sel_q      <= `APFCS_RST_SEL;
			sample_en_q     <= 1'b0;
			analog_pwr_en_q <= 1'b0;
			conv_end_irq    <= 1'b0;
			cmp0_q          <= 1'b0;
			sar_go_q        <= 1'b0;
			sar_kill_q      <= 1'b0;
		end else if (clk_en) begin
			conv_end_irq <= 1'b0;
			sar_go_q     <= 1'b0;
			sar_kill_q   <= 1'b0;
			if (!ce_q || stop_s) begin
				// powered down while disabled or in deepest standby
				st_q            <= ST_OFF;                               // R6 R11
				analog_pwr_en_q <= 1'b0;
				sample_en_q     <= 1'b0;
				sar_kill_q      <= (st_q != ST_OFF);
			end else if (cfg_wr_q && (st_q == ST_SAMP || st_q == ST_CONV || st_q == ST_NEXT)) begin
				// a config write restarts the pass from its first channel
				st_q        <= ST_SAMP;                                   // R9
				chan_sel_q  <= first_ch;
				cnt_q       <= SAMP_CYCLES;
				sample_en_q <= 1'b1;
				sar_kill_q  <= 1'b1;
			end else begin
				case (st_q)
					ST_OFF: begin
						// idle and subclock never reach here; only reset, enable clear or deepest standby does
						analog_pwr_en_q <= 1'b1;                          // R13
						st_q            <= ST_STAB;
						cnt_q           <= STAB_CYCLES;                   // R19
					end
					ST_STAB: begin
						if (cnt_q <= 16'h0001) begin
							st_q        <= ST_SAMP;
							chan_sel_q  <= first_ch;
							cnt_q       <= SAMP_CYCLES;
							sample_en_q <= 1'b1;
						end else begin
							cnt_q <= cnt_q - 16'h0001;
						end
					end
					ST_SAMP: begin
						if (cnt_q <= 16'h0001) begin
							st_q        <= ST_CONV;
							sample_en_q <= 1'b0;
							sar_go_q    <= 1'b1;
						end else begin
							cnt_q <= cnt_q - 16'h0001;
						end
					end
					ST_CONV: begin
						if (sar_done) begin
							st_q <= ST_NEXT;
							if (!scan_md) begin
								conv_end_irq <= pf_hit;                  // R1 R17
							end else begin
								// channel 0 alone decides the scan interrupt
								if (chan_sel_q == 4'h0)
									cmp0_q <= pf_hit;                     // R3
								if (chan_sel_q == last_ch)
									conv_end_irq <= (chan_sel_q == 4'h0) ? pf_hit : cmp0_q; // R3
							end
						end
					end
					ST_NEXT: begin
						cnt_q       <= SAMP_CYCLES;
						if (!scan_md) begin
							st_q        <= ST_SAMP;                       // R2
							sample_en_q <= 1'b1;
						end else if (chan_sel_q != last_ch) begin
							st_q        <= ST_SAMP;
							chan_sel_q  <= chan_sel_q + 4'h1;             // R4 R5
							sample_en_q <= 1'b1;
						end else if (md_q == `APFCS_MD_CSCAN) begin
							st_q        <= ST_SAMP;
							chan_sel_q  <= 4'h0;                          // R4
							sample_en_q <= 1'b1;
						end else begin
							st_q <= ST_HALT;                              // R5
						end
					end
					ST_HALT: begin
						// single pass done; stays until enable is cleared or deepest standby is entered
						st_q <= ST_HALT;                                  // R5
					end
					default: begin
						st_q <= ST_OFF;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// result store: overwritten in place, so read before the next pass
	// ---------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (rst) begin
			for (ri = 0; ri < `APFCS_NUM_CH; ri = ri + 1)
				res_q[ri] <= 10'h000;
		end else if (clk_en) begin
			if (st_q == ST_CONV && sar_done && ce_q && !stop_s && !cfg_wr_q)
				res_q[chan_sel_q] <= sar_res;                             // R1 R3 R10
		end
	end

	// ---------------------------------------------------------------
	// standby tracking and status flags
	// ---------------------------------------------------------------
	// set wins over a software clear in the same cycle
	always @(posedge sys_clk) begin
		if (rst) begin
			stop_p_q <= 1'b0;
			idle_p_q <= 1'b0;
			flag_q   <= 1'b0;
			stale_q  <= 1'b0;
		end else if (clk_en) begin
			stop_p_q <= stop_s;
			idle_p_q <= idle_s;
			// select rewrites do not touch the flag
			flag_q   <= (flag_q & ~(wr_go && wlane0_q && awaddr_q == `APFCS_OFF_STAT && wbyte_q[`APFCS_STAT_FLAG]))
			            | conv_end_irq;                                   // R7
			stale_q  <= (stale_q & ~(wr_go && wlane0_q && awaddr_q == `APFCS_OFF_STAT && wbyte_q[`APFCS_STAT_STALE]))
			            | (stop_p_q & ~stop_s)                            // R11
			            | (idle_p_q & ~idle_s);                           // R14
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite write channels
	// ---------------------------------------------------------------
	assign wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_idx = awaddr_q[5:2];
	assign wr_map = (awaddr_q[1:0] == 2'h0) && (awaddr_q <= `APFCS_OFF_STAT);
	assign wr_cfg = wr_map && (awaddr_q != `APFCS_OFF_STAT) && wlane0_q;

	// address and data taken in either order, answer two cycles after both
	always @(posedge sys_clk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `APFCS_RESP_OKAY;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= 8'h00;
			wbyte_q       <= 8'h00;
			wlane0_q      <= 1'b0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q     <= 1'b1;
				wbyte_q      <= s_axi_wdata[7:0];
				wlane0_q     <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `APFCS_RESP_OKAY : `APFCS_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// writable registers; only byte lane 0 carries data
	// ---------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (rst) begin
			ce_q     <= 1'b0;
			md_q     <= `APFCS_MD_CSEL;
			mode2_q  <= `APFCS_RST_BYTE;
			sel_q    <= `APFCS_RST_SEL;
			pf_en_q  <= 1'b0;
			pf_pol_q <= 1'b0;
			pft_q    <= `APFCS_RST_BYTE;
			cfg_wr_q <= 1'b0;
		end else if (clk_en) begin
			cfg_wr_q <= wr_go && wr_cfg;                                  // R9
			if (wr_go && wr_cfg) begin
				case (wr_idx)
					4'h0: begin
						ce_q <= wbyte_q[`APFCS_MODE0_CE];                 // R12
						md_q <= wbyte_q[`APFCS_MODE0_MD_HI:`APFCS_MODE0_MD_LO];
					end
					4'h1: mode2_q <= wbyte_q;
					4'h2: sel_q   <= wbyte_q[3:0];
					4'h3: begin
						pf_en_q  <= wbyte_q[`APFCS_PFM_EN];
						pf_pol_q <= wbyte_q[`APFCS_PFM_POL];
					end
					4'h4: pft_q <= wbyte_q;
					default: pft_q <= pft_q;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// read decode
	// ---------------------------------------------------------------
	assign rd_idx = s_axi_araddr[5:2]; // base is 64-byte aligned

	always @* begin
		rd_data = 32'h00000000;
		rd_ok   = (s_axi_araddr[1:0] == 2'h0);
		case (s_axi_araddr)
			`APFCS_OFF_MODE0: begin
				rd_data[`APFCS_MODE0_CE]   = ce_q;
				rd_data[`APFCS_MODE0_BUSY] = (st_q == ST_SAMP) || (st_q == ST_CONV) || (st_q == ST_NEXT);
				rd_data[`APFCS_MODE0_MD_HI:`APFCS_MODE0_MD_LO] = md_q;
			end
			`APFCS_OFF_MODE2: rd_data[7:0] = mode2_q;
			`APFCS_OFF_SEL:   rd_data[3:0] = sel_q;
			`APFCS_OFF_PFM: begin
				rd_data[`APFCS_PFM_EN]  = pf_en_q;
				rd_data[`APFCS_PFM_POL] = pf_pol_q;
			end
			`APFCS_OFF_PFT:   rd_data[7:0] = pft_q;
			`APFCS_OFF_STAT: begin
				rd_data[`APFCS_STAT_FLAG]  = flag_q;
				rd_data[`APFCS_STAT_STALE] = stale_q;
			end
			default: begin
				if (rd_ok && s_axi_araddr >= `APFCS_OFF_RES_BASE && s_axi_araddr <= `APFCS_OFF_RES_LAST)
					rd_data[9:0] = res_q[rd_idx];
				else
					rd_ok = 1'b0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read channel: data in the cycle after the address
	// ---------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `APFCS_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_data;
				s_axi_rresp   <= rd_ok ? `APFCS_RESP_OKAY : `APFCS_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // apfcs_top

// ===== sim/apfcs_analog_model.sv
// behavioural analog pins and comparator facing the sequencer
`timescale 1ns/100ps
module apfcs_analog_model (
	input  wire         sys_clk,
	input  wire [3:0]   chan_sel_q,
	input  wire [9:0]   dac_code,
	input  wire         analog_pwr_en_q,
	input  wire [119:0] levels,
	output wire         comp_in
);
	reg  [3:0] pin;
	reg        toggle_q = 1'h0;
	// selects past the last pin read the last pin
	always @* pin = (chan_sel_q > 4'hB) ? 4'hB : chan_sel_q;
	// unpowered comparator answers nothing: flip so no result settles by luck
	always @(posedge sys_clk) toggle_q <= ~toggle_q;
	// ideal comparator, high while the pin is at or above the trial code
	assign comp_in = analog_pwr_en_q ? (levels[pin*10 +: 10] >= dac_code) : toggle_q;
endmodule // apfcs_analog_model

// ===== sim/apfcs_properties.sv
// port assertions for the compare sequencer
`timescale 1ns/100ps
`include "apfcs_defines.vh"
module apfcs_properties #(
	parameter [15:0] STAB_CYCLES = 16'h0014
) (
	input wire        sys_clk,
	input wire        rst,
	input wire [7:0]  s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0]  s_axi_wstrb,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        stop_mode,
	input wire [3:0]  chan_sel_q,
	input wire        sample_en_q,
	input wire        analog_pwr_en_q,
	input wire        conv_end_irq
);
	// --------
	// sequences
	// --------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// both write channels taken at one edge
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// enable bit written to zero through lane 0
	sequence s_ce_off;
		s_wr_taken ##0 (s_axi_awaddr == `APFCS_OFF_MODE0 && s_axi_wstrb[0] && !s_axi_wdata[`APFCS_MODE0_CE]);
	endsequence
	// standby held long enough to pass the synchroniser
	sequence s_stop_held;
		stop_mode [*5];
	endsequence
	// --------
	// assertions
	// --------
	a_irq_one_pulse: assert property (conv_end_irq |=> !conv_end_irq)
		else $error("irq longer than one cycle");
	a_off_no_sample: assert property (!analog_pwr_en_q |-> !sample_en_q)
		else $error("sampling while unpowered");
	a_ce_clear_off: assert property (s_ce_off |-> ##[1:3] !analog_pwr_en_q)
		else $error("power kept after enable cleared");
	a_stop_powers_off: assert property (s_stop_held |-> !analog_pwr_en_q)
		else $error("power kept in standby");
	a_irq_powered: assert property (conv_end_irq |-> $past(analog_pwr_en_q, 2))
		else $error("irq without a powered conversion");
	a_chan_in_range: assert property (sample_en_q |-> chan_sel_q <= `APFCS_LAST_CH)
		else $error("channel past last pin");
	a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
endmodule // apfcs_properties

bind apfcs_top apfcs_properties #(.STAB_CYCLES(STAB_CYCLES)) u_props (.*);

// ===== sim/apfcs_top_test.sv
// self-checking bench for the compare sequencer
`timescale 1ns/100ps
`include "apfcs_defines.vh"
module apfcs_top_test;
	localparam logic [1:0] ok  = `APFCS_RESP_OKAY;
	localparam logic [1:0] err = `APFCS_RESP_SLVERR;
	reg          sys_clk, rst, clk_en, stop_mode, idle_mode;
	reg  [7:0]   s_axi_awaddr, s_axi_araddr;
	reg  [31:0]  s_axi_wdata;
	reg  [3:0]   s_axi_wstrb, lim;
	reg          s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [3:0]   chan_sel_q;
	wire [9:0]   dac_code;
	wire         sample_en_q, analog_pwr_en_q, conv_end_irq, comp_in;
	reg  [119:0] levels;
	int          num_errors, compares;

	apfcs_top #(.STAB_CYCLES(16'h0002)) uut (.*);
	apfcs_analog_model u_analog (.*);

	// --------
	// clock, guard and pin watch
	// --------
	initial begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end
	// hang guard, several times the expected run
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		end_sim;
	end
	// no pin past the last selected one is sampled
	always @(posedge sys_clk) begin
		if (sample_en_q === 1'h1 && chan_sel_q > lim) begin
			num_errors++;
			$display("ERROR chan_sel_q expected <= %h seen %h", lim, chan_sel_q);
		end
	end

	// --------
	// bus and check tasks
	// --------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		s_axi_bready <= 1'h0;
	endtask
	// one read compared against e
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		chk(nm, e, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		s_axi_rready <= 1'h0;
	endtask
	// wait up to n cycles for an irq pulse, then judge its presence
	task automatic exp_irq(input int n, input bit e);
		bit g;
		g = 1'h0;
		while (!g && n > 0) begin
			@(posedge sys_clk);
			g = (conv_end_irq === 1'h1);
			n--;
		end
		chk("conv_end_irq", {31'h0, e}, {31'h0, g});
	endtask
	function automatic logic [7:0] ra(input int ch);
		return `APFCS_OFF_RES_BASE + 8'(ch * 4);
	endfunction
	task automatic res_chk(input int last);
		for (int k = 0; k <= last; k++) rdc("result", ra(k), {22'h0, levels[k*10 +: 10]}, ok);
	endtask
	// configure only while stopped, flag cleared before each start
	task automatic cfg(input logic [1:0] md, input logic [3:0] sel, input logic [7:0] pfm, input logic [7:0] thr);
		wr(`APFCS_OFF_MODE0, 8'h00, ok);
		wr(`APFCS_OFF_STAT, 8'h03, ok);
		wr(`APFCS_OFF_SEL, {4'h0, sel}, ok);
		wr(`APFCS_OFF_PFM, pfm, ok);
		wr(`APFCS_OFF_PFT, thr, ok);
		lim = sel;
		wr(`APFCS_OFF_MODE0, {2'h2, md, 4'h0}, ok);
	endtask

	// --------
	// scenarios
	// --------
	task automatic t_regs;
		for (int a = 0; a <= 20; a += 4) rdc("reset value", 8'(a), 32'h0, ok);
		wr(`APFCS_OFF_MODE2, 8'h5A, ok);
		rdc("mode2", `APFCS_OFF_MODE2, 32'h5A, ok);
		wr(8'h18, 8'hFF, err);
		rdc("hole", 8'h18, 32'h0, err);
	endtask
	// compare off: each conversion of pin 5 interrupts and is stored
	task automatic t_select;
		levels[50 +: 10] <= 10'h155;
		cfg(`APFCS_MD_CSEL, 4'h5, 8'h00, 8'h00);
		exp_irq(150, 1'h1);
		exp_irq(150, 1'h1);
		rdc("result 5", ra(5), 32'h155, ok);
		rdc("status", `APFCS_OFF_STAT, 32'h1, ok);
	endtask
	// threshold boundary on both polarities, result kept either way
	task automatic t_pf;
		logic [9:0] lv [4];
		lv = '{10'h200, 10'h1FF, 10'h1FC, 10'h201};
		for (int i = 0; i < 4; i++) begin
			levels[30 +: 10] <= lv[i];
			cfg(`APFCS_MD_CSEL, 4'h3, {1'h1, i[1], 6'h0}, 8'h80);
			exp_irq(150, !i[0]);
			rdc("result 3", ra(3), {22'h0, lv[i]}, ok);
		end
	endtask
	// only pin 0 decides the pass irq; scan restarts at pin 0
	task automatic t_scan;
		levels[39:0] <= {10'h0C0, 10'h080, 10'h040, 10'h300};
		cfg(`APFCS_MD_CSCAN, 4'h3, 8'h80, 8'hA0);
		exp_irq(400, 1'h1);
		exp_irq(400, 1'h1);
		res_chk(3);
		levels[9:0] <= 10'h2FC;
		cfg(`APFCS_MD_CSCAN, 4'h3, 8'hC0, 8'hA0);
		exp_irq(400, 1'h0);
		rdc("result 0", ra(0), 32'h2FC, ok);
	endtask
	// one pass then halt; select rewrite leaves the flag set
	task automatic t_oneshot;
		levels[29:0] <= {10'h3FF, 10'h000, 10'h1A5};
		cfg(`APFCS_MD_OSCAN, 4'h2, 8'h80, 8'h00);
		exp_irq(400, 1'h1);
		exp_irq(200, 1'h0);
		rdc("mode0", `APFCS_OFF_MODE0, 32'hA0, ok);
		res_chk(2);
		wr(`APFCS_OFF_SEL, 8'h05, ok);
		rdc("status", `APFCS_OFF_STAT, 32'h1, ok);
		wr(`APFCS_OFF_STAT, 8'h01, ok);
		rdc("status", `APFCS_OFF_STAT, 32'h0, ok);
	endtask
	// idle keeps converting; idle and standby releases mark results stale
	task automatic t_standby;
		cfg(`APFCS_MD_CSEL, 4'h5, 8'h00, 8'h00);
		idle_mode <= 1'h1;
		exp_irq(150, 1'h1);
		idle_mode <= 1'h0;
		repeat (4) @(posedge sys_clk);
		rdc("status", `APFCS_OFF_STAT, 32'h3, ok);
		wr(`APFCS_OFF_MODE0, 8'h00, ok);
		wr(`APFCS_OFF_STAT, 8'h03, ok);
		stop_mode <= 1'h1;
		repeat (8) @(posedge sys_clk);
		chk("analog_pwr_en_q", 32'h0, {31'h0, analog_pwr_en_q});
		stop_mode <= 1'h0;
		repeat (4) @(posedge sys_clk);
		rdc("status", `APFCS_OFF_STAT, 32'h2, ok);
		wr(`APFCS_OFF_MODE0, 8'h80, ok);
		exp_irq(150, 1'h1);
	endtask

	task automatic end_sim;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// --------
	// main sequence
	// --------
	initial begin
		rst = 1'h1;
		clk_en = 1'h1;
		stop_mode = 1'h0;
		idle_mode = 1'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'h0;
		s_axi_wvalid = 1'h0;
		s_axi_bready = 1'h0;
		s_axi_arvalid = 1'h0;
		s_axi_rready = 1'h0;
		levels = 120'h0;
		lim = 4'hB;
		repeat (5) @(posedge sys_clk);
		rst <= 1'h0;
		t_regs;
		t_select;
		t_pf;
		t_scan;
		t_oneshot;
		t_standby;
		end_sim;
	end
endmodule // apfcs_top_test
